// file: bench/host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Host side of the byte register port
// ****************************************************************
module host_model (
	input  wire logic       sys_clk_in,     // System clock
	input  wire logic [7:0] rd_data_in,     // Read byte
	input  wire logic       rd_valid_in,    // Read byte valid
	output logic            acc_start_out,  // Pointer load pulse
	output logic [7:0]      acc_addr_out,   // Pointer value
	output logic            acc_wr_out,     // Write strobe
	output logic [7:0]      acc_wdata_out,  // Write byte
	output logic            acc_rd_out      // Read strobe
);
	logic [7:0] rd_buf [8];                 // Bytes of last read run
	int         miss_cnt;                   // Reads seen without valid

	// Idle bus at time zero
	initial begin
		acc_start_out = 1'b0;
		acc_addr_out  = 8'h00;
		acc_wr_out    = 1'b0;
		acc_wdata_out = 8'h00;
		acc_rd_out    = 1'b0;
		miss_cnt      = 0;
	end

	function automatic logic [7:0] defined_bits(input logic [7:0] a, input logic [7:0] v);
		case (a)
			8'h2b: return v & 8'hdf;
			8'h2c: return v & 8'h2f;
			8'h2d, 8'h2e: return v & 8'h97;
			default: return v;
		endcase
	endfunction

	// Load the pointer for one cycle, then scramble the released lines
	task automatic load_ptr(input logic [7:0] a);
		@(negedge sys_clk_in);
		acc_start_out = 1'b1;
		acc_addr_out  = a;
		@(negedge sys_clk_in);
		acc_start_out = 1'b0;
		acc_addr_out  = ~a;
	endtask

	// One byte write at a fresh pointer
	task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
		load_ptr(a);
		acc_wr_out    = 1'b1;
		acc_wdata_out = d;
		@(negedge sys_clk_in);
		acc_wr_out    = 1'b0;
		acc_wdata_out = ~d;
	endtask

	// low byte follows high
	// Burst of n reads; without a load it continues at the live pointer
	task automatic rd_seq(input logic [7:0] a, input int n, input bit ld);
		if (ld) begin
			load_ptr(a);
		end else begin
			@(negedge sys_clk_in);
		end
		acc_rd_out = 1'b1;
		for (int i = 0; i < n; i++) begin
			@(negedge sys_clk_in);
			if (rd_valid_in !== 1'b1) begin
				miss_cnt++;
			end
			rd_buf[i] = rd_data_in;
			if (i == n - 1) begin
				acc_rd_out = 1'b0;
			end
		end
	endtask
endmodule

// file: bench/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) check_val(nm, e, g)
// ****************************************************************
// Register map and sample status bench
// ****************************************************************
module tb;
	logic                          sys_clk_in;    // Clock
	logic                          reset_n_in;    // Reset, low
	accel_regmap_pkg::sample_set_t smp_in;        // Converter results
	logic [2:0]                    smp_new_in;    // Result strobes
	logic                          acc_start_in;  // Pointer load
	logic [7:0]                    acc_addr_in;   // Pointer value
	logic                          acc_wr_in;     // Write strobe
	logic [7:0]                    acc_wdata_in;  // Write byte
	logic                          acc_rd_in;     // Read strobe
	logic [7:0]                    rd_data_out;   // Read byte
	logic                          rd_valid_out;  // Read valid
	logic                          active_out;    // Active flag
	accel_regmap_pkg::cfg_regs_t   cfg_out;       // Writable registers
	logic [7:0]                    d;             // Last read byte
	logic [7:0]                    exp7 [7];      // Expected burst
	int                            err_count;     // Mismatches
	int                            checks;        // Comparisons

	// Clock, 5 ns period
	always #2.5 sys_clk_in = ~sys_clk_in;

	accel_sample_status_regmap u_dut (
		.sys_clk_in   (sys_clk_in),
		.reset_n_in   (reset_n_in),
		.smp_in       (smp_in),
		.smp_new_in   (smp_new_in),
		.acc_start_in (acc_start_in),
		.acc_addr_in  (acc_addr_in),
		.acc_wr_in    (acc_wr_in),
		.acc_wdata_in (acc_wdata_in),
		.acc_rd_in    (acc_rd_in),
		.rd_data_out  (rd_data_out),
		.rd_valid_out (rd_valid_out),
		.active_out   (active_out),
		.cfg_out      (cfg_out)
	);

	host_model u_host (
		.sys_clk_in    (sys_clk_in),
		.rd_data_in    (rd_data_out),
		.rd_valid_in   (rd_valid_out),
		.acc_start_out (acc_start_in),
		.acc_addr_out  (acc_addr_in),
		.acc_wr_out    (acc_wr_in),
		.acc_wdata_out (acc_wdata_in),
		.acc_rd_out    (acc_rd_in)
	);

	// Compare and count
	task automatic check_val(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Single register read
	task automatic rd_reg(input logic [7:0] a);
		u_host.rd_seq(a, 1, 1'b1);
		d = u_host.rd_buf[0];
	endtask

	// One-cycle result strobe
	task automatic inject(input logic [9:0] x, y, z, input logic [2:0] m);
		@(negedge sys_clk_in);
		smp_in.x   = x;
		smp_in.y   = y;
		smp_in.z   = z;
		smp_new_in = m;
		@(negedge sys_clk_in);
		smp_new_in = 3'h0;
	endtask

	// Verdict and end of run
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		for (int i = 0; i < 20000; i++) begin
			@(posedge sys_clk_in);
		end
		err_count++;
		$display("[ERR] watchdog expected finish seen timeout");
		conclude();
	end

	// Main sequence
	initial begin
		sys_clk_in = 1'b0;
		reset_n_in = 1'b0;
		smp_in     = '0;
		smp_new_in = 3'h0;
		err_count  = 0;
		checks     = 0;
		repeat (16) @(negedge sys_clk_in);
		reset_n_in = 1'b1;
		// Reset values of every writable register
		for (int i = 0; i < accel_regmap_pkg::NUM_CFG; i++) begin
			rd_reg(accel_regmap_pkg::CFG_ADDR[i]);
			`CHK("reset value", u_host.defined_bits(accel_regmap_pkg::CFG_ADDR[i],
				accel_regmap_pkg::CFG_RST[i]),
				u_host.defined_bits(accel_regmap_pkg::CFG_ADDR[i], d));
		end
		u_host.wr_byte(8'h13, 8'hff);
		rd_reg(8'h13);
		`CHK("read only 0x13", 8'h44, d);
		rd_reg(8'h14);
		`CHK("read only 0x14", 8'h84, d);
		u_host.wr_byte(8'h20, 8'hff);
		rd_reg(8'h20);
		`CHK("unmapped", 8'h00, d);
		$display("test reset done");
		// Standby write, then refused while active
		u_host.wr_byte(8'h17, 8'h3c);
		`CHK("cfg threshold", 8'h3c, cfg_out.motion_threshold);
		u_host.wr_byte(8'h2a, 8'h01);
		`CHK("active", 8'h01, {7'h00, active_out});
		u_host.wr_byte(8'h17, 8'h11);
		rd_reg(8'h17);
		`CHK("threshold held", 8'h3c, d);
		$display("test standby done");
		// Full burst of status and six sample bytes
		inject(10'h3fd, 10'h155, 10'h200, 3'h7);
		exp7 = '{8'h0f, 8'hff, 8'h40, 8'h55, 8'h40, 8'h80, 8'h00};
		u_host.rd_seq(8'h00, 7, 1'b1);
		for (int i = 0; i < 7; i++) begin
			`CHK("burst byte", exp7[i], u_host.rd_buf[i]);
		end
		rd_reg(8'h00);
		`CHK("status drained", 8'h00, d);
		$display("test burst done");
		// Overwrite of X, then high bytes read one by one
		inject(10'h005, 10'h000, 10'h000, 3'h1);
		inject(10'h005, 10'h000, 10'h000, 3'h1);
		rd_reg(8'h00);
		`CHK("status overrun", 8'h99, d);
		rd_reg(8'h01);
		`CHK("x high", 8'h01, d);
		rd_reg(8'h00);
		`CHK("status after x", 8'h88, d);
		rd_reg(8'h03);
		rd_reg(8'h05);
		rd_reg(8'h00);
		`CHK("status after all", 8'h00, d);
		$display("test overrun done");
		// Low byte stays paired with its high byte
		inject(10'h1c6, 10'h000, 10'h000, 3'h1);
		u_host.rd_seq(8'h01, 1, 1'b1);
		`CHK("pair high", 8'h71, u_host.rd_buf[0]);
		inject(10'h001, 10'h000, 10'h000, 3'h1);
		u_host.rd_seq(8'h00, 1, 1'b0);
		`CHK("pair low", 8'h80, u_host.rd_buf[0]);
		rd_reg(8'h00);
		`CHK("status new x", 8'h09, d);
		$display("test pairing done");
		// Fast read skips every low byte
		u_host.wr_byte(8'h2a, 8'h00);
		u_host.wr_byte(8'h2a, 8'h02);
		u_host.wr_byte(8'h2a, 8'h03);
		`CHK("cfg control", 8'h03, cfg_out.control_one);
		inject(10'h3fd, 10'h155, 10'h200, 3'h7);
		exp7 = '{8'h9f, 8'hff, 8'h55, 8'h80, 8'h00, 8'h00, 8'h00};
		u_host.rd_seq(8'h00, 5, 1'b1);
		for (int i = 0; i < 5; i++) begin
			`CHK("fast byte", exp7[i], u_host.rd_buf[i]);
		end
		rd_reg(8'h00);
		`CHK("fast drained", 8'h00, d);
		$display("test fast done");
		// Results dropped in standby
		u_host.wr_byte(8'h2a, 8'h02);
		inject(10'h3fd, 10'h155, 10'h200, 3'h7);
		rd_reg(8'h00);
		`CHK("standby status", 8'h00, d);
		// Software reset accepted while active
		u_host.wr_byte(8'h2a, 8'h01);
		u_host.wr_byte(8'h2b, 8'h40);
		repeat (3) @(negedge sys_clk_in);
		`CHK("active cleared", 8'h00, {7'h00, active_out});
		rd_reg(8'h17);
		`CHK("threshold reset", 8'h00, d);
		rd_reg(8'h11);
		`CHK("orient reset", 8'h80, d);
		`CHK("read valid", 8'h00, u_host.miss_cnt[7:0]);
		$display("test soft reset done");
		conclude();
	end
endmodule

// file: src/accel_regmap_pkg.sv
package accel_regmap_pkg;

	// ****************************************************************
	// Widths and counts
	// ****************************************************************
	localparam int SAMPLE_W = 10;            // Converter result width
	localparam int NUM_AXES = 3;             // X, Y, Z
	localparam int NUM_CFG  = 14;            // Writable byte registers

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] ADDR_STATUS     = 8'h00;
	localparam logic [7:0] ADDR_X_MSB      = 8'h01;
	localparam logic [7:0] ADDR_X_LSB      = 8'h02;
	localparam logic [7:0] ADDR_Y_MSB      = 8'h03;
	localparam logic [7:0] ADDR_Y_LSB      = 8'h04;
	localparam logic [7:0] ADDR_Z_MSB      = 8'h05;
	localparam logic [7:0] ADDR_Z_LSB      = 8'h06;
	localparam logic [7:0] ADDR_ORIENT_CFG = 8'h11;
	localparam logic [7:0] ADDR_ORIENT_BFZ = 8'h13;
	localparam logic [7:0] ADDR_ORIENT_THS = 8'h14;
	localparam logic [7:0] ADDR_MOTION_SRC = 8'h16;
	localparam logic [7:0] ADDR_CONTROL_1  = 8'h2a;
	localparam logic [7:0] ADDR_CONTROL_2  = 8'h2b;
	localparam logic [7:0] ADDR_LAST       = 8'h31;

	// Writable registers in index order, with reset values and masks
	localparam logic [7:0] CFG_ADDR [NUM_CFG] = '{
		8'h11, 8'h12, 8'h15, 8'h17, 8'h18, 8'h29, 8'h2a,
		8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h31};
	localparam logic [7:0] CFG_RST [NUM_CFG] = '{
		8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] CFG_MASK [NUM_CFG] = '{
		8'hc0, 8'hff, 8'hf8, 8'hff, 8'hff, 8'hff, 8'hfb,
		8'hdf, 8'h2b, 8'h95, 8'h95, 8'hff, 8'hff, 8'hff};

	// ****************************************************************
	// Field positions and fixed values
	// ****************************************************************
	localparam int CTRL1_ACTIVE_BIT = 0;     // Active / standby
	localparam int CTRL1_FAST_BIT   = 1;     // Skip low bytes
	localparam int CTRL2_RST_BIT    = 6;     // Software reset
	localparam logic [7:0] CTRL1_ACTIVE_MASK = 8'h01;
	localparam logic [7:0] CTRL2_RST_MASK    = 8'h40;
	localparam logic [7:0] ORIENT_BFZ_VAL    = 8'h44;
	localparam logic [7:0] ORIENT_THS_VAL    = 8'h84;
	localparam logic [7:0] MOTION_SRC_VAL    = 8'h00;
	localparam logic [7:0] UNMAPPED_VAL      = 8'h00;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef logic signed [SAMPLE_W-1:0] sample_t;

	// One result per axis, two's complement
	typedef struct packed {
		sample_t z;
		sample_t y;
		sample_t x;
	} sample_set_t;

	// Writable registers as seen by the rest of the device
	typedef struct packed {
		logic [7:0] z_offset_trim;
		logic [7:0] y_offset_trim;
		logic [7:0] x_offset_trim;
		logic [7:0] interrupt_pin_map;
		logic [7:0] interrupt_enable;
		logic [7:0] control_three;
		logic [7:0] control_two;
		logic [7:0] control_one;
		logic [7:0] autosleep_counter;
		logic [7:0] motion_debounce;
		logic [7:0] motion_threshold;
		logic [7:0] motion_config;
		logic [7:0] orient_debounce;
		logic [7:0] orient_config;
	} cfg_regs_t;

endpackage

// file: src/accel_sample_status_regmap.sv
`timescale 1ns/1ps
// Contract
// - Fast read skips all low-byte registers
// - Normal burst: six sample bytes in order
// - Status bits: overruns high, readies low
// - Combined overrun sets on any overwrite
// - Combined overrun clears after all high bytes
// - Axis overrun sets when unread sample replaced
// - Axis high byte read clears overrun
// - Samples are two's complement values
// - Low byte pairs with preceding high byte
// - Combined ready sets on result, clears on reads
// - Config writes only in standby, two exceptions
module accel_sample_status_regmap (
	input  wire logic                         sys_clk_in,     // 200 MHz clock
	input  wire logic                         reset_n_in,     // Async reset, low
	input  wire accel_regmap_pkg::sample_set_t smp_in,        // Converter results
	input  wire logic [2:0]                   smp_new_in,     // Per axis strobe, x=0
	input  wire logic                         acc_start_in,   // Load register pointer
	input  wire logic [7:0]                   acc_addr_in,    // Pointer value
	input  wire logic                         acc_wr_in,      // Byte write strobe
	input  wire logic [7:0]                   acc_wdata_in,   // Byte to write
	input  wire logic                         acc_rd_in,      // Byte read strobe
	output logic [7:0]                        rd_data_out,    // Read byte
	output logic                              rd_valid_out,   // Read byte valid
	output logic                              active_out,     // Device active
	output accel_regmap_pkg::cfg_regs_t       cfg_out         // Writable registers
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	localparam int W = accel_regmap_pkg::SAMPLE_W;

	logic [7:0]          ptr_r;             // Register pointer
	logic [7:0]          ptr_nxt;           // Pointer after access
	logic [7:0]          cfg_r [accel_regmap_pkg::NUM_CFG]; // Writable bytes
	logic [accel_regmap_pkg::NUM_CFG*8-1:0] cfg_flat;       // Packed view
	logic                soft_rst_r;        // Software reset pulse
	logic                fast_read;         // Low byte skip enable
	logic signed [W-1:0] axis_in [3];       // Results by axis index
	logic signed [W-1:0] axis_q [3];        // Held results
	logic [2:0]          axis_new;          // Accepted result strobes
	logic [2:0]          axis_rdy;          // Per axis ready
	logic [2:0]          axis_ovr;          // Per axis overwrite
	logic [2:0]          msb_rd;            // High byte read strobes
	logic [2:0]          seen_r;            // High bytes read since set
	logic                all_seen;          // Every high byte read
	logic                all_rdy_r;         // Combined ready
	logic                all_ovr_r;         // Combined overwrite
	logic [1:0]          lsb_r [3];         // Low bits latched at high read
	logic [7:0]          status_w;          // Status register view
	logic [7:0]          rd_mux;            // Byte at pointer

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Pointer step after a read or write access
	function automatic logic [7:0] step_ptr(input logic [7:0] p, input logic fast);
		logic [7:0] n;
		n = p + 8'h01;
		// high byte jumps over its low byte
		if (fast && (p == accel_regmap_pkg::ADDR_X_MSB || p == accel_regmap_pkg::ADDR_Y_MSB
			|| p == accel_regmap_pkg::ADDR_Z_MSB)) begin
			n = p + 8'h02;
		end
		// Wrap after the last register
		if (p >= accel_regmap_pkg::ADDR_LAST) begin
			n = accel_regmap_pkg::ADDR_STATUS;
		end
		return n;
	endfunction

	// Axis index of a sample address, 3 when not a sample byte
	function automatic logic [1:0] axis_of(input logic [7:0] p);
		logic [1:0] a;
		a = 2'h3;
		if (p >= accel_regmap_pkg::ADDR_X_MSB && p <= accel_regmap_pkg::ADDR_Z_LSB) begin
			a = 2'((p - 8'h01) >> 1);
		end
		return a;
	endfunction

	// ****************************************************************
	// Result slots
	// ****************************************************************
	assign axis_in[0] = smp_in.x;
	assign axis_in[1] = smp_in.y;
	assign axis_in[2] = smp_in.z;

	// Results only land while active
	assign axis_new = active_out ? smp_new_in : 3'h0;

	// High byte read of an axis
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_axis
			assign msb_rd[g] = acc_rd_in && (ptr_r == 8'(8'h01 + 2 * g));

			axis_sample_slot #(
				.W (W)
			) u_slot (
				.sys_clk_in  (sys_clk_in),
				.reset_n_in  (reset_n_in),
				.clear_in    (soft_rst_r),
				.new_in      (axis_new[g]),
				.data_in     (axis_in[g]),
				.msb_rd_in   (msb_rd[g]),
				.sample_out  (axis_q[g]),
				.ready_out   (axis_rdy[g]),
				.overrun_out (axis_ovr[g])
			);

			// low bits caught with the high byte
			always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					lsb_r[g] <= 2'h0;
				end else if (msb_rd[g]) begin
					lsb_r[g] <= axis_q[g][1:0];
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Combined flags
	// ****************************************************************
	// Tracks high byte reads; a new result re-arms its axis
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			seen_r <= 3'h0;
		end else if (soft_rst_r || all_seen) begin
			seen_r <= 3'h0;
		end else begin
			seen_r <= (seen_r | msb_rd) & ~axis_new;
		end
	end

	assign all_seen = &(seen_r | msb_rd);

	// combined ready, set wins over clear
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			all_rdy_r <= 1'b0;
		end else if (soft_rst_r) begin
			all_rdy_r <= 1'b0;
		end else if (|axis_new) begin
			all_rdy_r <= 1'b1;
		end else if (all_seen) begin
			all_rdy_r <= 1'b0;
		end
	end

	// cleared only once all high bytes read, or by software reset
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			all_ovr_r <= 1'b0;
		end else if (soft_rst_r) begin
			all_ovr_r <= 1'b0;
		end else if (|(axis_new & axis_rdy)) begin
			all_ovr_r <= 1'b1;
		end else if (all_seen) begin
			all_ovr_r <= 1'b0;
		end
	end

	assign status_w = {all_ovr_r, axis_ovr[2], axis_ovr[1], axis_ovr[0],
		all_rdy_r, axis_rdy[2], axis_rdy[1], axis_rdy[0]};

	// ****************************************************************
	// Register pointer
	// ****************************************************************
	assign fast_read = cfg_r[6][accel_regmap_pkg::CTRL1_FAST_BIT];
	assign ptr_nxt   = step_ptr(ptr_r, fast_read);

	// Loads on start, steps on each byte access
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ptr_r <= 8'h00;
		end else if (acc_start_in) begin
			ptr_r <= acc_addr_in;
		end else if (acc_rd_in || acc_wr_in) begin
			// one step per byte in normal mode
			ptr_r <= ptr_nxt;
		end
	end

	// ****************************************************************
	// Writable registers
	// ****************************************************************
	generate
		for (g = 0; g < accel_regmap_pkg::NUM_CFG; g++) begin : gen_cfg
			logic [7:0] wmask;    // Bits this write may change

			// only active bit and reset bit open while active
			always_comb begin
				wmask = 8'h00;
				if (!active_out) begin
					wmask = accel_regmap_pkg::CFG_MASK[g];
				end else if (accel_regmap_pkg::CFG_ADDR[g] == accel_regmap_pkg::ADDR_CONTROL_1) begin
					wmask = accel_regmap_pkg::CTRL1_ACTIVE_MASK;
				end else if (accel_regmap_pkg::CFG_ADDR[g] == accel_regmap_pkg::ADDR_CONTROL_2) begin
					wmask = accel_regmap_pkg::CTRL2_RST_MASK;
				end
			end

			// Masked byte write; software reset restores defaults
			always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					cfg_r[g] <= accel_regmap_pkg::CFG_RST[g];
				end else if (soft_rst_r) begin
					cfg_r[g] <= accel_regmap_pkg::CFG_RST[g];
				end else if (acc_wr_in && ptr_r == accel_regmap_pkg::CFG_ADDR[g]) begin
					cfg_r[g] <= (cfg_r[g] & ~wmask) | (acc_wdata_in & wmask);
				end
			end

			assign cfg_flat[g*8 +: 8] = cfg_r[g];
		end
	endgenerate

	// Software reset fires the cycle after its bit is written
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= cfg_r[7][accel_regmap_pkg::CTRL2_RST_BIT] && !soft_rst_r;
		end
	end

	assign active_out = cfg_r[6][accel_regmap_pkg::CTRL1_ACTIVE_BIT];
	assign cfg_out    = accel_regmap_pkg::cfg_regs_t'(cfg_flat);

	// ****************************************************************
	// Read path
	// ****************************************************************
	// Byte at the pointer; unmapped and undefined bits read zero
	always_comb begin
		logic [1:0] ax;
		ax     = axis_of(ptr_r);
		rd_mux = accel_regmap_pkg::UNMAPPED_VAL;
		if (ptr_r == accel_regmap_pkg::ADDR_STATUS) begin
			rd_mux = status_w;
		end else if (ax != 2'h3) begin
			// two's complement, high byte then low pair
			if (ptr_r[0]) begin
				rd_mux = axis_q[ax][W-1:2];
			end else begin
				rd_mux = {lsb_r[ax], 6'h00};
			end
		end else if (ptr_r == accel_regmap_pkg::ADDR_ORIENT_BFZ) begin
			rd_mux = accel_regmap_pkg::ORIENT_BFZ_VAL;
		end else if (ptr_r == accel_regmap_pkg::ADDR_ORIENT_THS) begin
			rd_mux = accel_regmap_pkg::ORIENT_THS_VAL;
		end else if (ptr_r == accel_regmap_pkg::ADDR_MOTION_SRC) begin
			rd_mux = accel_regmap_pkg::MOTION_SRC_VAL;
		end else begin
			for (int i = 0; i < accel_regmap_pkg::NUM_CFG; i++) begin
				if (ptr_r == accel_regmap_pkg::CFG_ADDR[i]) begin
					rd_mux = cfg_r[i];
				end
			end
		end
	end

	// Read byte held until the next read
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rd_data_out <= 8'h00;
		end else if (acc_rd_in) begin
			rd_data_out <= rd_mux;
		end
	end

	// One-cycle valid after each read
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rd_valid_out <= 1'b0;
		end else begin
			rd_valid_out <= acc_rd_in;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	sequence s_x_msb_read;
		acc_rd_in && !acc_start_in && ptr_r == accel_regmap_pkg::ADDR_X_MSB && !fast_read;
	endsequence

	sequence s_next_lsb_read;
		acc_rd_in && !acc_start_in;
	endsequence

	chk_fast_skip: assert property (
		acc_rd_in && !acc_start_in && fast_read && ptr_r == accel_regmap_pkg::ADDR_Y_MSB
		|=> ptr_r == accel_regmap_pkg::ADDR_Z_MSB)
		else $error("fast read did not skip low byte");

	chk_burst_step: assert property (
		acc_rd_in && !acc_start_in && !fast_read && ptr_r >= 8'h01 && ptr_r <= 8'h05
		|=> ptr_r == $past(ptr_r) + 8'h01)
		else $error("burst pointer did not step by one");

	chk_status_bits: assert property (
		acc_rd_in && ptr_r == accel_regmap_pkg::ADDR_STATUS
		|=> rd_data_out[7] == $past(all_ovr_r) && rd_data_out[3] == $past(all_rdy_r)
			&& rd_data_out[6:4] == $past(axis_ovr) && rd_data_out[2:0] == $past(axis_rdy))
		else $error("status byte layout wrong");

	chk_all_ovr_set: assert property (
		|(axis_new & axis_rdy) && !soft_rst_r |=> all_ovr_r)
		else $error("combined overwrite not set");

	chk_all_ovr_clear: assert property (
		$fell(all_ovr_r) |-> $past(all_seen || soft_rst_r))
		else $error("combined overwrite cleared early");

	chk_axis_ovr_set: assert property (
		axis_new[0] && axis_rdy[0] && !soft_rst_r |=> axis_ovr[0])
		else $error("axis overwrite not set");

	chk_axis_ovr_clr: assert property (
		msb_rd[0] && !axis_new[0] |=> !axis_ovr[0])
		else $error("axis overwrite not cleared by high read");

	chk_twos_msb: assert property (
		s_x_msb_read |=> rd_data_out == $past(axis_q[0][W-1:2]))
		else $error("high byte not sample top bits");

	chk_lsb_pairing: assert property (
		s_x_msb_read ##1 s_next_lsb_read
		|=> rd_data_out == {$past(axis_q[0][1:0], 2), 6'h00})
		else $error("low byte not from same sample");

	chk_all_rdy_set: assert property (
		|axis_new && !soft_rst_r |=> all_rdy_r)
		else $error("combined ready not set");

	chk_standby_lock: assert property (
		acc_wr_in && !acc_start_in && active_out && !soft_rst_r
			&& ptr_r == accel_regmap_pkg::CFG_ADDR[3]
		|=> $stable(cfg_r[3]))
		else $error("config changed while active");

endmodule

// file: src/axis_sample_slot.sv
`timescale 1ns/1ps
// Holds one axis result with its ready and overrun flags
module axis_sample_slot #(
	parameter int W = 10
) (
	input  wire logic                sys_clk_in,    // System clock
	input  wire logic                reset_n_in,    // Async reset, low
	input  wire logic                clear_in,      // Software reset pulse
	input  wire logic                new_in,        // New result strobe
	input  wire logic signed [W-1:0] data_in,       // New result
	input  wire logic                msb_rd_in,     // High byte read strobe
	output logic signed [W-1:0]      sample_out,    // Held result
	output logic                     ready_out,     // New data flag
	output logic                     overrun_out    // Overwrite flag
);

	// ****************************************************************
	// Result store
	// ****************************************************************
	// Newest result replaces the old one
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sample_out <= '0;
		end else if (clear_in) begin
			sample_out <= '0;
		end else if (new_in) begin
			sample_out <= data_in;
		end
	end

	// ****************************************************************
	// Flags
	// ****************************************************************
	// ready per axis: set by result, cleared by high byte read
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ready_out <= 1'b0;
		end else if (clear_in) begin
			ready_out <= 1'b0;
		end else if (new_in) begin
			ready_out <= 1'b1;          // Set wins over clear
		end else if (msb_rd_in) begin
			ready_out <= 1'b0;
		end
	end

	// overwrite when result lands on unread one
	// high byte read clears it, set still wins
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			overrun_out <= 1'b0;
		end else if (clear_in) begin
			overrun_out <= 1'b0;
		end else if (new_in && ready_out) begin
			overrun_out <= 1'b1;
		end else if (msb_rd_in) begin
			overrun_out <= 1'b0;
		end
	end

endmodule
